/* sfp_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides
module sfp_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic in_valid_in,
  input wire logic [W-1:0] in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output logic [W-1:0] out_data_out,
  input wire logic out_ready_in
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D + 1);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic push;
  logic pop;

  assign in_ready_out = (count != CW'(D));
  assign out_valid_out = (count != '0);
  assign out_data_out = mem[rd_ptr];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_ready_in & out_valid_out;

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= AW'(wr_ptr + 1'b1);
      end
      if (pop) begin
        rd_ptr <= AW'(rd_ptr + 1'b1);
      end
      if (push && !pop) begin
        count <= CW'(count + 1'b1);
      end else if (pop && !push) begin
        count <= CW'(count - 1'b1);
      end
    end
  end
endmodule // sfp_fifo

/* sfp_front.sv */
// Pin-level serial flash front end: shifter, decoder, dual read output
// Summary of operation
// - Instruction, address and data bits are captured on rising serial clock edges.
// - The dual output fast read turns the input lane into a second output lane.
// - Read data and status change on falling serial clock edges.
// - With chip select high both data outputs are floated.
// - Deselect means standby, while an internal operation already running goes on.
// - With chip select low the device takes instructions and returns data.
// - No instruction is accepted before a high to low chip select after power-up.
// - Pause low while selected floats the output and ignores data and clock.
// - Protect pin and lock bit block status writes; nonzero guard bits block the full wipe.
// - The read, program, erase, sleep, wake and identify opcodes are decoded.
// - Both clock idle levels, low and high, work alike.
// - Dual output lasts until chip select rises.
// - Chip select rising during a pause resets the serial logic.
`include "sfp_params.svh"
module sfp_front (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic sck_in,
  input wire logic cs_n_in,
  input wire logic hold_n_in,
  input wire logic protect_n_in,
  input wire logic data_in_lane_zero_in,
  output logic data_in_lane_zero_out,
  output logic data_in_lane_zero_oe_out,
  output logic so_out,
  output logic so_oe_out,
  input wire logic status_lock_bit_in,
  input wire logic [3:0] array_guard_bits_in,
  input wire logic busy_in,
  input wire logic [7:0] rd_data_in,
  input wire logic rd_valid_in,
  output logic rd_ready_out,
  output logic cmd_valid_out,
  output logic [7:0] cmd_opcode_out,
  output logic [23:0] cmd_addr_out,
  output logic cmd_refused_out,
  output logic wr_valid_out,
  output logic [7:0] wr_byte_out,
  output logic standby_out,
  output logic sleep_out
);
  import sfp_pkg::*;

  logic [4:0] pins_f;
  logic sck_f;
  logic cs_f;
  logic hold_f;
  logic prot_f;
  logic lane0_f;
  logic sck_d;
  logic sck_rise;
  logic sck_fall;
  logic armed;
  logic selected;
  logic held;
  logic live;
  sfp_state_t state;
  logic [2:0] bit_cnt;
  logic [1:0] byte_cnt;
  logic [7:0] in_sh;
  logic [7:0] nb;
  logic [7:0] opcode;
  logic [15:0] addr_hi;
  logic dual;
  logic blocked;
  logic byte_done;
  logic [2:0] out_cnt;
  logic [7:0] out_sh;
  logic driving;
  logic pop;
  logic fifo_valid;
  logic [7:0] fifo_data;
  logic [7:0] next_byte;
  logic issue;
  logic [7:0] issue_op;
  logic [23:0] issue_addr;
  logic refuse;
  logic status_locked;

  sfp_sync #(.W(`SFP_SYNC_WIDTH)) u_sync (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .d_in({sck_in, cs_n_in, hold_n_in, protect_n_in, data_in_lane_zero_in}),
    .q_out(pins_f)
  );
  assign {sck_f, cs_f, hold_f, prot_f, lane0_f} = pins_f;

  sfp_fifo #(.W(8), .D(`SFP_FIFO_DEPTH)) u_fifo (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .in_valid_in(rd_valid_in),
    .in_data_in(rd_data_in),
    .in_ready_out(rd_ready_out),
    .out_valid_out(fifo_valid),
    .out_data_out(fifo_data),
    .out_ready_in(pop)
  );

  // Edge finding only; no idle level assumed, so mode 0 and 3 look alike
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sck_d <= 1'b0;
    end else begin
      sck_d <= sck_f;
    end
  end
  assign sck_rise = sck_f & ~sck_d;
  assign sck_fall = ~sck_f & sck_d;

  // Filter resets low, so a high must really be seen before arming
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      armed <= 1'b0;
    end else if (cs_f) begin
      armed <= 1'b1;
    end
  end
  assign selected = armed & ~cs_f;

  // Pause takes effect only while the clock is low; it ends with the clock low or when chip select rises
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      held <= 1'b0;
    end else if (cs_f) begin
      held <= 1'b0;
    end else if (!sck_f) begin
      held <= ~hold_f;
    end
  end
  assign live = selected & ~held;

  assign nb = {in_sh[6:0], lane0_f};
  assign byte_done = live & sck_rise & (bit_cnt == `SFP_BIT_LAST);
  // Shifter and opcode decoder
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= SFP_ST_OPCODE;
      bit_cnt <= 3'h0;
      byte_cnt <= 2'h0;
      in_sh <= 8'h00;
      opcode <= 8'h00;
      addr_hi <= 16'h0000;
      dual <= 1'b0;
    end else if (!selected) begin
      state <= SFP_ST_OPCODE;
      bit_cnt <= 3'h0;
      byte_cnt <= 2'h0;
      dual <= 1'b0;
    end else if (live && sck_rise) begin
      in_sh <= nb;
      bit_cnt <= 3'(bit_cnt + 1'b1);
      if (bit_cnt == `SFP_BIT_LAST) begin
        case (state)
          SFP_ST_OPCODE: begin
            opcode <= nb;
            byte_cnt <= 2'h0;
            if (sleep_out && nb != `SFP_OP_WAKE) begin
              state <= SFP_ST_DONE;
            end else begin
              case (nb)
                `SFP_OP_READ, `SFP_OP_FAST_READ, `SFP_OP_PAGE_WRITE, `SFP_OP_SMALL_WIPE,
                `SFP_OP_LARGE_WIPE, `SFP_OP_MAKER_ID, `SFP_OP_WAKE: begin
                  state <= SFP_ST_ADDR;
                end
                `SFP_OP_DUAL_READ: begin
                  state <= SFP_ST_ADDR;
                  dual <= 1'b1;
                end
                `SFP_OP_ID_QUERY: state <= SFP_ST_OUT;
                `SFP_OP_STATUS_WRITE: state <= SFP_ST_WDATA;
                default: state <= SFP_ST_DONE;
              endcase
            end
          end
          SFP_ST_ADDR: begin
            addr_hi <= {addr_hi[7:0], nb};
            byte_cnt <= 2'(byte_cnt + 1'b1);
            if (byte_cnt == `SFP_ADDR_LAST) begin
              case (opcode)
                `SFP_OP_READ, `SFP_OP_MAKER_ID, `SFP_OP_WAKE: state <= SFP_ST_OUT;
                `SFP_OP_FAST_READ, `SFP_OP_DUAL_READ: state <= SFP_ST_DUMMY;
                `SFP_OP_PAGE_WRITE: state <= SFP_ST_WDATA;
                default: state <= SFP_ST_DONE;
              endcase
            end
          end
          SFP_ST_DUMMY: state <= SFP_ST_OUT;
          default: state <= state;
        endcase
      end
    end
  end

  // Command hand-off toward the array controller
  assign status_locked = status_lock_bit_in & ~prot_f;
  always_comb begin
    issue = 1'b0;
    issue_op = opcode;
    issue_addr = 24'h000000;
    if (byte_done && state == SFP_ST_OPCODE && !(sleep_out && nb != `SFP_OP_WAKE)) begin
      issue_op = nb;
      issue = (nb == `SFP_OP_ID_QUERY) || (nb == `SFP_OP_FULL_WIPE) || (nb == `SFP_OP_SLEEP)
        || (nb == `SFP_OP_WR_ENABLE) || (nb == `SFP_OP_WR_DISABLE) || (nb == `SFP_OP_STATUS_WRITE);
    end else if (byte_done && state == SFP_ST_ADDR && byte_cnt == `SFP_ADDR_LAST) begin
      issue = 1'b1;
      issue_addr = {addr_hi, nb};
    end
    // Running internal operation is left alone; new writes are refused
    refuse = (busy_in && issue_op != `SFP_OP_READ && issue_op != `SFP_OP_FAST_READ
      && issue_op != `SFP_OP_DUAL_READ)
      || (issue_op == `SFP_OP_FULL_WIPE && array_guard_bits_in != 4'h0)
      || (issue_op == `SFP_OP_STATUS_WRITE && status_locked);
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cmd_valid_out <= 1'b0;
      cmd_opcode_out <= 8'h00;
      cmd_addr_out <= 24'h000000;
      cmd_refused_out <= 1'b0;
      blocked <= 1'b0;
    end else begin
      cmd_valid_out <= issue;
      if (issue) begin
        cmd_opcode_out <= issue_op;
        cmd_addr_out <= issue_addr;
        cmd_refused_out <= refuse;
        blocked <= refuse;
      end
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_valid_out <= 1'b0;
      wr_byte_out <= 8'h00;
    end else begin
      wr_valid_out <= byte_done && state == SFP_ST_WDATA && !blocked;
      if (byte_done && state == SFP_ST_WDATA) begin
        wr_byte_out <= nb;
      end
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sleep_out <= 1'b0;
    end else if (byte_done && state == SFP_ST_OPCODE) begin
      if (nb == `SFP_OP_SLEEP && !busy_in) begin
        sleep_out <= 1'b1;
      end else if (nb == `SFP_OP_WAKE) begin
        sleep_out <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      standby_out <= 1'b1;
    end else begin
      standby_out <= ~selected;
    end
  end

  // Output shifter; an empty FIFO reads as erased bytes
  assign pop = live & sck_fall & (state == SFP_ST_OUT) & (out_cnt == 3'h0);
  assign next_byte = fifo_valid ? fifo_data : `SFP_IDLE_BYTE;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      out_cnt <= 3'h0;
      out_sh <= 8'h00;
      so_out <= 1'b0;
      data_in_lane_zero_out <= 1'b0;
      driving <= 1'b0;
    end else if (!selected) begin
      out_cnt <= 3'h0;
      driving <= 1'b0;
    end else if (live && sck_fall && state == SFP_ST_OUT) begin
      driving <= 1'b1;
      if (out_cnt == 3'h0) begin
        so_out <= next_byte[7];
        data_in_lane_zero_out <= next_byte[6];
        out_sh <= dual ? {next_byte[5:0], 2'b00} : {next_byte[6:0], 1'b0};
        out_cnt <= dual ? `SFP_DUAL_LAST : `SFP_BIT_LAST;
      end else begin
        so_out <= out_sh[7];
        data_in_lane_zero_out <= out_sh[6];
        out_sh <= dual ? {out_sh[5:0], 2'b00} : {out_sh[6:0], 1'b0};
        out_cnt <= 3'(out_cnt - 1'b1);
      end
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      so_oe_out <= 1'b0;
      data_in_lane_zero_oe_out <= 1'b0;
    end else begin
      so_oe_out <= live & (driving | (sck_fall & state == SFP_ST_OUT));
      data_in_lane_zero_oe_out <= live & dual & (driving | (sck_fall & state == SFP_ST_OUT));
    end
  end

  AST_OE_OFF_DESELECT: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    cs_f |=> !so_oe_out && !data_in_lane_zero_oe_out)
    else $error("output driven while deselected");
  AST_HOLD_FLOATS: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    held |=> !so_oe_out)
    else $error("output driven during pause");
  AST_IO0_ONLY_DUAL: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    data_in_lane_zero_oe_out |-> $past(dual) && so_oe_out)
    else $error("lane zero driven outside dual read");
  AST_OUT_ON_FALL: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    $changed(so_out) |-> $past(sck_fall) && $past(live))
    else $error("output changed away from falling edge");
  AST_NO_ARM: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !armed |=> !cmd_valid_out && !wr_valid_out)
    else $error("instruction taken before select edge");
  AST_STEP_ON_RISE: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (state != $past(state)) && $past(selected) |-> $past(sck_rise))
    else $error("decoder stepped without rising clock");
  AST_IDLE_ON_CS: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    $rose(cs_f) |=> state == SFP_ST_OPCODE && bit_cnt == 3'h0 && !dual)
    else $error("chip select rise did not reset decoder");
  AST_FULL_WIPE_GUARD: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    cmd_valid_out && cmd_opcode_out == `SFP_OP_FULL_WIPE && $past(array_guard_bits_in) != 4'h0 |-> cmd_refused_out)
    else $error("guarded full wipe not refused");
  AST_DUAL_HOLDS: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    dual && selected |=> dual)
    else $error("dual mode left while selected");
  AST_STANDBY: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    cs_f |=> standby_out)
    else $error("no standby while deselected");
endmodule // sfp_front

/* sfp_host.sv */
// Host side model that drives the serial pins and resolves the shared lines
module sfp_host (
  input wire logic clk_in,
  input wire logic so_in,
  input wire logic so_oe_in,
  input wire logic d0_in,
  input wire logic d0_oe_in,
  output logic sck_out,
  output logic cs_n_out,
  output logic hold_n_out,
  output logic lane0_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic cpol = 1'b0;
  logic mosi = 1'b0;
  logic drv = 1'b1;
  logic so_last = 1'b0;
  logic io_last = 1'b0;
  logic so_w;
  // Select starts low so the first frame is not armed
  initial begin
    sck_out = 1'b0;
    cs_n_out = 1'b0;
    hold_n_out = 1'b1;
  end
  // Released lines show the inverse of the last driven level, so a late sample cannot pass
  assign so_w = so_oe_in ? so_in : ~so_last;
  assign lane0_out = d0_oe_in ? d0_in : (drv ? mosi : ~io_last);
  always @(posedge clk_in) begin
    if (so_oe_in) so_last <= so_in;
    if (d0_oe_in || drv) io_last <= lane0_out;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic sel(input logic c);
    wt(1);
    cpol <= c;
    sck_out <= c;
    wt(16);
    cs_n_out <= 1'b0;
    drv <= 1'b1;
    wt(8);
  endtask
  task automatic desel();
    wt(8);
    sck_out <= cpol;
    wt(8);
    cs_n_out <= 1'b1;
    wt(16);
  endtask
  task automatic xb(input logic [7:0] t, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      sck_out <= 1'b0;
      mosi <= t[i];
      wt(7);
      r[i] = so_w;
      wt(1);
      sck_out <= 1'b1;
      wt(8);
    end
  endtask
  // Lane zero is let go for the whole dual data phase
  task automatic xd(output logic [7:0] r);
    drv <= 1'b0;
    for (int i = 3; i >= 0; i--) begin
      sck_out <= 1'b0;
      wt(7);
      r[2*i+1] = so_w;
      r[2*i] = lane0_out;
      wt(1);
      sck_out <= 1'b1;
      wt(8);
    end
  endtask
  // Pause pin falls at once and rises only with the clock low
  task automatic hold(input logic h);
    if (!h) hold_n_out <= 1'b0;
    wt(8);
    sck_out <= 1'b0;
    wt(8);
    hold_n_out <= h;
    wt(16);
  endtask
endmodule // sfp_host

/* sfp_params.svh */
// Constants of the serial flash pin front end
`ifndef SFP_PARAMS_SVH
`define SFP_PARAMS_SVH
`define SFP_OP_READ 8'h03
`define SFP_OP_FAST_READ 8'h0B
`define SFP_OP_DUAL_READ 8'h3B
`define SFP_OP_PAGE_WRITE 8'h02
`define SFP_OP_SMALL_WIPE 8'h20
`define SFP_OP_LARGE_WIPE 8'hD8
`define SFP_OP_FULL_WIPE 8'hC7
`define SFP_OP_SLEEP 8'hB9
`define SFP_OP_WAKE 8'hAB
`define SFP_OP_MAKER_ID 8'h90
`define SFP_OP_ID_QUERY 8'h9F
`define SFP_OP_WR_ENABLE 8'h06
`define SFP_OP_WR_DISABLE 8'h04
`define SFP_OP_STATUS_WRITE 8'h01
`define SFP_IDLE_BYTE 8'hFF
`define SFP_ADDR_LAST 2'h2
`define SFP_BIT_LAST 3'h7
`define SFP_DUAL_LAST 3'h3
`define SFP_FIFO_DEPTH 4
`define SFP_SYNC_WIDTH 5
`endif

/* sfp_pkg.sv */
// Types of the serial flash pin front end
package sfp_pkg;
  typedef enum logic [2:0] {
    SFP_ST_OPCODE = 3'b000,
    SFP_ST_ADDR = 3'b001,
    SFP_ST_DUMMY = 3'b010,
    SFP_ST_OUT = 3'b011,
    SFP_ST_WDATA = 3'b100,
    SFP_ST_DONE = 3'b101
  } sfp_state_t;
endpackage

/* sfp_sync.sv */
// Three-stage pin synchroniser with agreement filter
module sfp_sync #(
  parameter int W = 1
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= d_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Change accepted only when stages two and three agree
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      q_out <= '0;
    end else begin
      q_out <= (s2 & s3) | (q_out & (s2 | s3));
    end
  end
endmodule // sfp_sync

/* tb_top.sv */
// Self-checking bench for the serial flash pin front end
`include "sfp_params.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic prot_n = 1'b1;
  logic lock = 1'b0;
  logic busy = 1'b0;
  logic rv = 1'b0;
  logic [3:0] guard = 4'h0;
  logic [7:0] rd = 8'h00;
  logic [7:0] r;
  wire sck, cs_n, hold_n, lane0, d0_o, d0_oe, so, so_oe, rdy, cv, ref_o, wv, stby, slp;
  wire [7:0] op, wb;
  wire [23:0] adr;
  int num_errors = 0;
  int tests_run = 0;
  int ncmd = 0;
  int nwr = 0;
  int n0, n1;
  logic [7:0] ops [13] = '{8'h03, 8'h0B, 8'h3B, 8'h02, 8'h20, 8'hD8, 8'hC7, 8'h9F, 8'h90, 8'h06, 8'h04,
    8'hB9, 8'hAB};
  int nad [13] = '{3, 4, 4, 3, 3, 3, 0, 0, 3, 0, 0, 0, 3};
  // Case word: opcode, guard, lock, protect, busy, refusal expected
  logic [15:0] rc [6] = '{16'hC715, 16'hC704, 16'h0109, 16'h010C, 16'h2007, 16'h0306};
  logic [7:0] dx [3] = '{8'h96, 8'h3C, 8'hFF};
  initial forever #5 clk = ~clk;
  sfp_front dut_u (.clk_in(clk), .reset_n_in(rst_n), .sck_in(sck), .cs_n_in(cs_n), .hold_n_in(hold_n),
    .protect_n_in(prot_n), .data_in_lane_zero_in(lane0), .data_in_lane_zero_out(d0_o),
    .data_in_lane_zero_oe_out(d0_oe), .so_out(so), .so_oe_out(so_oe), .status_lock_bit_in(lock),
    .array_guard_bits_in(guard), .busy_in(busy), .rd_data_in(rd), .rd_valid_in(rv), .rd_ready_out(rdy),
    .cmd_valid_out(cv), .cmd_opcode_out(op), .cmd_addr_out(adr), .cmd_refused_out(ref_o),
    .wr_valid_out(wv), .wr_byte_out(wb), .standby_out(stby), .sleep_out(slp));
  sfp_host host_u (.clk_in(clk), .so_in(so), .so_oe_in(so_oe), .d0_in(d0_o), .d0_oe_in(d0_oe),
    .sck_out(sck), .cs_n_out(cs_n), .hold_n_out(hold_n), .lane0_out(lane0));
  always @(posedge clk) begin
    if (cv === 1'b1) ncmd++;
    if (wv === 1'b1) nwr++;
  end
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("Counts: %0d compares, %0d mismatches", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Address bytes 12h, 34h, 56h; a fourth is the dummy
  task automatic cmd(input logic [7:0] o, input int na, input logic c);
    host_u.sel(c);
    host_u.xb(o, r);
    for (int i = 0; i < na; i++) host_u.xb(8'h12 + 8'(34 * i), r);
  endtask
  task automatic push(input logic [7:0] d);
    int n = 0;
    @(posedge clk);
    rv <= 1'b1;
    rd <= d;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 50);
    rv <= 1'b0;
  endtask
  initial begin
    repeat (80000) @(posedge clk);
    num_errors++;
    stop_test();
  end
  initial begin
    repeat (6) @(posedge clk);
    chk(24'({stby, so_oe, d0_oe, rdy, cv, slp}), 24'h24);
    rst_n <= 1'b1;
    $display("test reset done");
    repeat (10) @(posedge clk);
    cmd(`SFP_OP_WR_ENABLE, 0, 1'b0);
    host_u.desel();
    chk(24'(ncmd), 24'h0);
    cmd(`SFP_OP_WR_ENABLE, 0, 1'b0);
    host_u.desel();
    chk(24'(ncmd), 24'h1);
    $display("test arming done");
    foreach (ops[i]) begin
      n0 = ncmd;
      cmd(ops[i], nad[i], 1'b0);
      host_u.desel();
      chk(24'(ncmd - n0), 24'h1);
      chk(24'(op), 24'(ops[i]));
      if (nad[i] != 0) chk(adr, 24'h123456);
      chk(24'(slp), 24'(ops[i] == `SFP_OP_SLEEP));
    end
    $display("test opcodes done");
    foreach (rc[i]) begin
      {guard, lock, prot_n, busy} <= rc[i][7:1];
      n1 = nwr;
      cmd(rc[i][15:8], (rc[i][15:8] inside {8'h20, 8'h03}) ? 3 : 0, 1'b0);
      if (rc[i][15:8] == `SFP_OP_STATUS_WRITE) host_u.xb(8'hA5, r);
      host_u.desel();
      chk(24'(ref_o), 24'(rc[i][0]));
      chk(24'(nwr - n1), 24'(rc[i][15:8] == 8'h01 && !rc[i][0]));
      if (nwr != n1) chk(24'(wb), 24'hA5);
    end
    {guard, lock, prot_n, busy} <= 7'h02;
    $display("test protection done");
    for (int m = 0; m < 2; m++) begin
      for (int i = 0; i < 4; i++) push(8'hA0 + 8'(i));
      @(posedge clk);
      chk(24'(rdy), 24'h0);
      cmd(`SFP_OP_READ, 3, m[0]);
      for (int i = 0; i < 5; i++) begin
        host_u.xb(8'h00, r);
        chk(24'(r), (i < 4) ? 24'hA0 + 24'(i) : 24'hFF);
      end
      chk(24'({so_oe, stby}), 24'h2);
      host_u.desel();
      chk(24'({so_oe, stby}), 24'h1);
    end
    $display("test single read done");
    push(8'h96);
    push(8'h3C);
    cmd(`SFP_OP_DUAL_READ, 4, 1'b0);
    for (int i = 0; i < 3; i++) begin
      host_u.xd(r);
      chk(24'({d0_oe, r}), 24'({1'b1, dx[i]}));
    end
    host_u.desel();
    chk(24'({d0_oe, so_oe}), 24'h0);
    $display("test dual read done");
    push(8'h5A);
    cmd(`SFP_OP_READ, 3, 1'b0);
    host_u.xb(8'h00, r);
    chk(24'(r), 24'h5A);
    host_u.hold(1'b0);
    chk(24'(so_oe), 24'h0);
    host_u.desel();
    host_u.hold(1'b1);
    n0 = ncmd;
    host_u.sel(1'b0);
    host_u.hold(1'b0);
    host_u.xb(`SFP_OP_ID_QUERY, r);
    host_u.hold(1'b1);
    host_u.xb(`SFP_OP_WR_DISABLE, r);
    host_u.desel();
    chk(24'(ncmd - n0), 24'h1);
    chk(24'(op), 24'h04);
    $display("test pause done");
    stop_test();
  end
endmodule // tb_top
